// *** verilog/csp_serial_port.sv ***
// Serial control port: link-side shifter and system-side register access
module csp_serial_port (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_CTRL_SHIFT_CLOCK,
  input wire logic I_CS_N,
  input wire logic I_CTRL_SERIAL_IN,
  input wire logic [csp_pkg::DATA_BITS-1:0] I_STATUS,
  output logic O_CTRL_SERIAL_OUT,
  output logic O_CTRL_SERIAL_OUT_OE,
  output logic O_CFG_WR_STB,
  output logic [csp_pkg::ADDR_W-1:0] O_CFG_ADDR,
  output logic [csp_pkg::DATA_BITS-1:0] O_CFG_DATA
);
  // Link domain state
  logic [csp_pkg::CNT_W-1:0] cnt_r;
  logic [csp_pkg::INSTR_BITS-1:0] sh_r;
  logic [csp_pkg::INSTR_BITS-1:0] instr_r;
  logic [csp_pkg::ADDR_W-1:0] wr_addr_r;
  logic [csp_pkg::DATA_BITS-1:0] wr_data_r;
  logic [csp_pkg::ADDR_W-1:0] rd_addr_r;
  logic wr_tog_r;
  logic rd_tog_r;
  logic [csp_pkg::DATA_BITS-2:0] osh_r;
  logic out_r;

  // System domain state
  logic wr_s1_r;
  logic wr_s2_r;
  logic wr_seen_r;
  logic rd_s1_r;
  logic rd_s2_r;
  logic rd_seen_r;
  logic rd_pend_r;
  logic [csp_pkg::ADDR_W-1:0] rd_addr_hold_r;
  logic [csp_pkg::DATA_BITS-1:0] rd_word_r;
  logic stb_r;
  logic [csp_pkg::ADDR_W-1:0] cfg_addr_r;
  logic [csp_pkg::DATA_BITS-1:0] cfg_data_r;
  logic [csp_pkg::DATA_BITS-1:0] bank_rdata;

  // Counter position match
  function automatic logic cnt_at(
    input logic [csp_pkg::CNT_W-1:0] cnt,
    input logic [csp_pkg::CNT_W-1:0] pos
  );
    cnt_at = (cnt == pos);
  endfunction

  // Saturating bit count step
  function automatic logic [csp_pkg::CNT_W-1:0] cnt_step(
    input logic [csp_pkg::CNT_W-1:0] cnt
  );
    cnt_step = cnt_at(cnt, csp_pkg::CNT_RDATA_END) ? cnt : cnt + 5'h01;
  endfunction

  // Toggle event detect
  function automatic logic tog_evt(
    input logic synced,
    input logic seen
  );
    tog_evt = synced ^ seen;
  endfunction

  // Link-side decode
  wire [csp_pkg::INSTR_BITS-1:0] sh_nxt = {sh_r[csp_pkg::INSTR_BITS-2:0], I_CTRL_SERIAL_IN};
  wire instr_done = cnt_at(cnt_r, csp_pkg::CNT_INSTR_LAST);
  wire instr_is_read = sh_nxt[csp_pkg::INSTR_READ_POS];
  wire is_read = instr_r[csp_pkg::INSTR_READ_POS];
  wire wdata_done = cnt_at(cnt_r, csp_pkg::CNT_WDATA_LAST) && !is_read;
  wire cnt_sat = cnt_at(cnt_r, csp_pkg::CNT_RDATA_END);
  wire [csp_pkg::CNT_W-1:0] cnt_nxt = cnt_step(cnt_r);
  wire rd_load = is_read && cnt_at(cnt_r, csp_pkg::CNT_RDATA_FIRST);
  wire rd_shift = is_read && (cnt_r > csp_pkg::CNT_RDATA_FIRST) && !cnt_sat;

  // Bit counter and input shifter, cleared whenever select is high
  // select frames transfer
  always_ff @(posedge I_CTRL_SHIFT_CLOCK or posedge I_CS_N)
  begin
    if (I_CS_N)
    begin
      cnt_r <= csp_pkg::CNT_RESET;
      sh_r <= csp_pkg::REG_RESET;
      instr_r <= csp_pkg::REG_RESET;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      if (instr_done)
        instr_r <= sh_nxt;
    end
  end

  // Captured words and event toggles, kept across frames
  // instruction picks direction
  always_ff @(posedge I_CTRL_SHIFT_CLOCK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      wr_tog_r <= 1'b0;
      rd_tog_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= csp_pkg::REG_RESET;
      rd_addr_r <= '0;
    end
    else if (!I_CS_N)
    begin
      if (instr_done && instr_is_read)
      begin
        rd_addr_r <= sh_nxt[csp_pkg::ADDR_W-1:0];
        rd_tog_r <= ~rd_tog_r;
      end
      if (wdata_done)
      begin
        wr_addr_r <= instr_r[csp_pkg::ADDR_W-1:0];
        wr_data_r <= sh_nxt;
        wr_tog_r <= ~wr_tog_r;
      end
    end
  end

  // Output shifter on falling edges
  // falling-edge output change
  always_ff @(negedge I_CTRL_SHIFT_CLOCK or posedge I_CS_N)
  begin
    if (I_CS_N)
    begin
      out_r <= 1'b0;
      osh_r <= '0;
    end
    else if (rd_load)
    begin
      out_r <= rd_word_r[csp_pkg::DATA_BITS-1];
      osh_r <= rd_word_r[csp_pkg::DATA_BITS-2:0];
    end
    else if (rd_shift)
    begin
      out_r <= osh_r[csp_pkg::DATA_BITS-2];
      osh_r <= {osh_r[csp_pkg::DATA_BITS-3:0], 1'b0};
    end
  end

  assign O_CTRL_SERIAL_OUT = out_r;
  assign O_CTRL_SERIAL_OUT_OE = ~I_CS_N;

  // System-side event detection
  wire wr_evt = tog_evt(wr_s2_r, wr_seen_r);
  wire rd_evt = tog_evt(rd_s2_r, rd_seen_r);
  wire rd_take = rd_evt && !wr_evt;
  wire [csp_pkg::ADDR_W-1:0] bank_addr = wr_evt ? wr_addr_r : rd_addr_r;
  wire is_status = (rd_addr_hold_r == csp_pkg::STATUS_ADDR);

  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_seen_r <= 1'b0;
      rd_s1_r <= 1'b0;
      rd_s2_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end
    else
    begin
      wr_s1_r <= wr_tog_r;
      wr_s2_r <= wr_s1_r;
      wr_seen_r <= wr_s2_r;
      rd_s1_r <= rd_tog_r;
      rd_s2_r <= rd_s1_r;
      rd_seen_r <= rd_s2_r;
    end
  end

  // Read word fetch and write strobe
  // words taken after handshake
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      rd_pend_r <= 1'b0;
      rd_addr_hold_r <= '0;
      rd_word_r <= csp_pkg::REG_RESET;
      stb_r <= 1'b0;
      cfg_addr_r <= '0;
      cfg_data_r <= csp_pkg::REG_RESET;
    end
    else
    begin
      rd_pend_r <= rd_take;
      if (rd_take)
        rd_addr_hold_r <= rd_addr_r;
      if (rd_pend_r)
        rd_word_r <= is_status ? I_STATUS : bank_rdata;
      stb_r <= wr_evt;
      if (wr_evt)
      begin
        cfg_addr_r <= wr_addr_r;
        cfg_data_r <= wr_data_r;
      end
    end
  end

  assign O_CFG_WR_STB = stb_r;
  assign O_CFG_ADDR = cfg_addr_r;
  assign O_CFG_DATA = cfg_data_r;

  csp_reg_bank u_bank (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_we(wr_evt),
    .i_addr(bank_addr),
    .i_wdata(wr_data_r),
    .o_rdata(bank_rdata)
  );
endmodule

// *** verilog/csp_pkg.sv ***
// Constants shared by the serial control port files
package csp_pkg;
  localparam int unsigned INSTR_BITS = 8;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned INSTR_READ_POS = 7;
  localparam logic [CNT_W-1:0] CNT_INSTR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_WDATA_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_RDATA_FIRST = 5'h10;
  localparam logic [CNT_W-1:0] CNT_RDATA_END = 5'h18;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'hf;
  localparam logic [DATA_BITS-1:0] REG_RESET = 8'h00;
  localparam int unsigned REG_COUNT = 16;
endpackage

// *** verilog/csp_reg_bank.sv ***
// Control register storage with registered read data
module csp_reg_bank (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [csp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [csp_pkg::DATA_BITS-1:0] i_wdata,
  output logic [csp_pkg::DATA_BITS-1:0] o_rdata
);
  logic [csp_pkg::DATA_BITS-1:0] mem_r [csp_pkg::REG_COUNT];
  logic [csp_pkg::DATA_BITS-1:0] rdata_r;

  assign o_rdata = rdata_r;

  // Storage and read port
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < csp_pkg::REG_COUNT; i++)
        mem_r[i] <= csp_pkg::REG_RESET;
      rdata_r <= csp_pkg::REG_RESET;
    end
    else
    begin
      if (i_we)
        mem_r[i_addr] <= i_wdata;
      rdata_r <= mem_r[i_addr];
    end
  end
endmodule

// *** verification/csp_mcu_model.sv ***
// Controller model driving the serial control link
module csp_mcu_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_sck, o_cs_n, o_sdi} <= 3'h2;
  task automatic frame(input logic [15:0] w, input int n, output logic [7:0] rd);
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_sdi = (i < 16) ? w[15 - i] : ~o_sdi;
      #16 o_sck = 1'b1;
      if (i >= 16)
        rd = {rd[6:0], i_sdo};
      #16 o_sck = 1'b0;
    end
    #8 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #40;
  endtask
endmodule

// *** verification/csp_serial_port_sva.sv ***
// Checker for the serial control port
module csp_serial_port_sva (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_CTRL_SHIFT_CLOCK,
  input wire logic I_CS_N,
  input wire logic I_CTRL_SERIAL_IN,
  input wire logic [csp_pkg::DATA_BITS-1:0] I_STATUS,
  input wire logic O_CTRL_SERIAL_OUT,
  input wire logic O_CTRL_SERIAL_OUT_OE,
  input wire logic O_CFG_WR_STB,
  input wire logic [csp_pkg::ADDR_W-1:0] O_CFG_ADDR,
  input wire logic [csp_pkg::DATA_BITS-1:0] O_CFG_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  sequence quiet_s;
    !O_CFG_WR_STB [*3];
  endsequence
  pin_drive_a: assert property (O_CTRL_SERIAL_OUT_OE == !I_CS_N) else $error("oe");
  out_idle_a: assert property (I_CS_N && $past(I_CS_N) |-> !O_CTRL_SERIAL_OUT) else $error("idle");
  out_sel_a: assert property ($changed(O_CTRL_SERIAL_OUT) |-> !I_CS_N || !$past(I_CS_N)) else $error("out");
  stb_once_a: assert property ($rose(O_CFG_WR_STB) |=> quiet_s) else $error("stb");
  stb_frame_a: assert property (O_CFG_WR_STB |-> !$past(I_CS_N, 4)) else $error("frame");
  addr_upd_a: assert property ($changed(O_CFG_ADDR) |-> O_CFG_WR_STB) else $error("addr");
  data_upd_a: assert property ($changed(O_CFG_DATA) |-> O_CFG_WR_STB) else $error("data");
  rst_val_a: assert property ($rose(I_RSTN) |-> !O_CFG_WR_STB && O_CFG_ADDR == 4'h0) else $error("rst");
endmodule
bind csp_serial_port csp_serial_port_sva i_sva (.*);

// *** verification/csp_serial_port_tb.sv ***
// Testbench for the serial control port
module csp_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b1, sck, cs_n, sdi, sdo, oe, stb;
  logic [7:0] status = 8'h00, data, rd;
  logic [3:0] addr;
  logic [7:0] mem [16] = '{default: 8'h00};
  logic [11:0] q [$];
  logic [7:0] rq [$];
  event rd_ev;
  logic [16:0] lf = 17'h1746b;
  int n_fail = 0, num_checks = 0;
  csp_mcu_model i_mcu (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(oe ? sdo : 1'b1));
  csp_serial_port i_dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_CTRL_SHIFT_CLOCK(sck), .I_CS_N(cs_n),
    .I_CTRL_SERIAL_IN(sdi), .I_STATUS(status), .O_CTRL_SERIAL_OUT(sdo), .O_CTRL_SERIAL_OUT_OE(oe),
    .O_CFG_WR_STB(stb), .O_CFG_ADDR(addr), .O_CFG_DATA(data));
  initial forever #10 clk = ~clk;
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    lfsr = {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, int n);
    lf = lfsr(lf);
    if (n >= 16)
    begin
      q.push_back({a, lf[7:0]});
      mem[a] = lf[7:0];
    end
    i_mcu.frame({1'b0, lf[10:8], a, lf[7:0]}, n, rd);
  endtask
  task automatic rdck(logic [3:0] a);
    lf = lfsr(lf);
    rq.push_back((a == 4'hf) ? status : mem[a]);
    i_mcu.frame({1'b1, lf[10:8], a, lf[7:0]}, 24, rd);
    -> rd_ev;
  endtask
  always @(rd_ev)
    chk("read", {4'h0, rd}, {4'h0, ((rq.size() > 0) ? rq.pop_front() : 8'hxx)});
  always @(negedge clk)
    if (stb === 1'b1)
      chk("write", {addr, data}, (q.size() > 0) ? q.pop_front() : 12'hxxx);
  initial
  begin
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 48; i++)
      if (i / 16 == 1)
        wr(i[3:0], i[0] ? 16 : 20);
      else
        rdck(i[3:0]);
    wr(4'h3, 9);
    @(posedge clk) status <= lf[16:9];
    rdck(4'h3);
    rdck(4'hf);
    repeat (8) @(posedge clk);
    chk("queue", 12'(q.size() + rq.size()), 12'h000);
    print_verdict();
  end
  initial
  begin
    #100us;
    n_fail++;
    print_verdict();
  end
endmodule
